// *** rtl/io_port_defs.svh ***
`ifndef IO_PORT_DEFS_SVH
`define IO_PORT_DEFS_SVH
`define EN_SERIAL_COUNT   0
`define EN_INPUT_IRQ      1
`define EN_PORT_DRIVE     2
`define EN_SERIAL_OUT     3
`define ENABLE_RESET      4'h0
`define LATCH_RESET       8'h00
`define SERIAL_RESET      4'h0
`define SHIFT_DIV_DEFAULT 16
`define SHIFT_DIV_W       8
`endif

// *** rtl/io_port_pkg.sv ***
package io_port_pkg;
  typedef struct packed {
    logic       latch_load_op;
    logic       latch_readback_op;
    logic       port_pins_read_op;
    logic       acc_serial_swap_op;
    logic       general_inputs_read_op;
    logic       latched_inputs_read_op;
    logic       enable_write_op;
  } cpu_ops_t;
  typedef struct packed {
    logic [3:0] acc;
    logic [3:0] mem;
    logic       carry;
  } cpu_data_t;
endpackage

// *** rtl/mcu_io_ports.sv ***
`timescale 1ns/10ps
`include "io_port_defs.svh"
module mcu_io_ports #(
  parameter int SHIFT_DIV = `SHIFT_DIV_DEFAULT
) (
  // clock and reset
  input  wire logic                    i_clk,
  input  wire logic                    i_rst,
  // instruction side
  input  wire io_port_pkg::cpu_ops_t   i_ops,
  input  wire io_port_pkg::cpu_data_t  i_data,
  input  wire logic                    i_host_mode,
  input  wire logic                    i_ready_level,
  output logic [3:0]                   o_acc,
  output logic [3:0]                   o_mem,
  output logic                         o_acc_valid,
  output logic [3:0]                   o_enable,
  output logic                         o_irq_req,
  // parallel port pins
  input  wire logic [7:0]              i_port,
  output logic [7:0]                   o_port,
  output logic [7:0]                   o_port_oe,
  // serial pins
  input  wire logic                    i_serial_in,
  output logic                         o_serial_out,
  output logic                         o_serial_clock_pin,
  // general inputs and oscillator pin
  input  wire logic [3:0]              i_gen_in,
  input  wire logic                    i_oscillator_out_pin,
  // host ready line
  output logic                         o_ready_request_line,
  output logic                         o_ready_oe
);
  import io_port_pkg::*;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // high-to-low step between two samples of a synced pin
  function automatic logic fell(input logic prev, input logic cur);
    return prev && !cur;
  endfunction

  // ----------------------------------------
  // input synchronisation
  // ----------------------------------------
  logic [7:0] port_s;
  logic [3:0] gen_s;
  logic       si_s;
  logic       osc_s;
  sync2 #(.W(14)) u_sync (
    .i_clk (i_clk),
    .i_rst (i_rst),
    .i_d   ({i_port, i_gen_in, i_serial_in, i_oscillator_out_pin}),
    .o_q   ({port_s, gen_s, si_s, osc_s})
  );

  // ----------------------------------------
  // enable register and latch
  // ----------------------------------------
  logic [3:0] enable;
  logic [7:0] out_latch;
  logic [3:0] serial_shift_count_reg;
  logic [1:0] pulse_catch;
  logic [3:0] gen_prev;
  logic       clk_level;
  logic [`SHIFT_DIV_W-1:0] div_cnt;

  wire serial_counter_select_bit = enable[`EN_SERIAL_COUNT];
  wire input_interrupt_enable_bit = enable[`EN_INPUT_IRQ];
  wire port_drive_enable_bit = enable[`EN_PORT_DRIVE];
  wire serial_out_control_bit = enable[`EN_SERIAL_OUT];

  // new enable value acts from the cycle after the write
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      enable <= `ENABLE_RESET;
    else if (i_ops.enable_write_op)
      enable <= i_data.acc;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      out_latch <= `LATCH_RESET;
    else if (i_ops.latch_load_op)
      out_latch <= {i_data.acc, i_data.mem};
  end

  // ----------------------------------------
  // serial register and shift clock
  // ----------------------------------------
  // the shift clock is a slow divided enable so external
  // shift registers see clean edges
  // divider rests while shifting is off, so setting bit 3
  // never opens with a short clock pulse
  wire shift_run = !serial_counter_select_bit && serial_out_control_bit;
  wire div_tick = (div_cnt == `SHIFT_DIV_W'(SHIFT_DIV - 1));
  wire shift_rise = div_tick && !clk_level;
  wire do_shift = shift_rise && shift_run;
  logic si_prev;
  wire si_fall = fell(si_prev, si_s);
  wire do_count = serial_counter_select_bit && si_fall;
  logic carry_out;

  always_ff @(posedge i_clk)
  begin
    if (i_rst || !shift_run)
    begin
      div_cnt   <= '0;
      clk_level <= 1'b0;
    end
    else
    begin
      div_cnt   <= div_tick ? '0 : div_cnt + 1'b1;
      if (div_tick)
        clk_level <= !clk_level;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      si_prev <= 1'b1;
    else
      si_prev <= si_s;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      serial_shift_count_reg <= `SERIAL_RESET;
    else if (i_ops.acc_serial_swap_op)
      serial_shift_count_reg <= i_data.acc;
    else if (do_shift)
      serial_shift_count_reg <= {serial_shift_count_reg[2:0], si_s};
    else if (do_count)
      serial_shift_count_reg <= serial_shift_count_reg + 4'h1;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      carry_out <= 1'b0;
    else if (i_ops.acc_serial_swap_op)
      carry_out <= i_data.carry;
  end

  wire shift_clk_gated = clk_level && serial_out_control_bit;
  assign o_serial_out = serial_counter_select_bit
                        ? serial_out_control_bit
                        : serial_shift_count_reg[3];
  assign o_serial_clock_pin = serial_counter_select_bit
                              ? carry_out
                              : shift_clk_gated;

  // ----------------------------------------
  // general inputs
  // ----------------------------------------
  wire take_latched = i_ops.latched_inputs_read_op;
  wire [1:0] fall03 = {fell(gen_prev[3], gen_s[3]),
                       fell(gen_prev[0], gen_s[0])};

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      gen_prev    <= 4'hF;
      pulse_catch <= 2'b00;
    end
    else
    begin
      gen_prev <= gen_s;
      // a new pulse beats the clearing read
      pulse_catch <= fall03
                     | (take_latched ? 2'b00 : pulse_catch);
    end
  end

  wire irq_fall = fell(gen_prev[1], gen_s[1]);
  assign o_irq_req = input_interrupt_enable_bit && irq_fall;

  // ----------------------------------------
  // read data back to accumulator and memory
  // ----------------------------------------
  logic [3:0] next_acc;
  logic [3:0] next_mem;
  logic       next_valid;
  always_comb
  begin
    next_acc   = 4'h0;
    next_mem   = 4'h0;
    next_valid = 1'b1;
    if (i_ops.port_pins_read_op)
      {next_acc, next_mem} = port_s;
    else if (i_ops.latch_readback_op)
      {next_acc, next_mem} = out_latch;
    else if (i_ops.acc_serial_swap_op)
      next_acc = serial_shift_count_reg;
    else if (i_ops.general_inputs_read_op)
      next_acc = gen_s;
    else if (take_latched)
      next_acc = {pulse_catch[1], osc_s, 1'b0, pulse_catch[0]};
    else
      next_valid = 1'b0;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      o_acc       <= 4'h0;
      o_mem       <= 4'h0;
      o_acc_valid <= 1'b0;
    end
    else
    begin
      o_acc       <= next_acc;
      o_mem       <= next_mem;
      o_acc_valid <= next_valid;
    end
  end

  // ----------------------------------------
  // parallel port drive and host bus
  // ----------------------------------------
  // host strobes: select on input 2, write on 3
  wire host_cs_n = gen_s[2];
  wire host_wr_n = gen_s[3];
  wire host_drive = !host_cs_n && !host_wr_n;
  wire drive_on = i_host_mode ? host_drive : port_drive_enable_bit;

  // both active devices off when not driving
  assign o_port_oe = drive_on ? 8'hFF : 8'h00;
  assign o_port = drive_on ? out_latch : 8'h00;
  assign o_ready_request_line = i_ready_level;
  assign o_ready_oe = i_host_mode;
  assign o_enable = enable;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking chk_cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  float_off_a: assert property (
    (!i_host_mode && !port_drive_enable_bit) |-> o_port_oe == 8'h00)
    else $error("port driven while disabled");
  drive_latch_a: assert property (
    (!i_host_mode && port_drive_enable_bit)
    |-> o_port == out_latch && o_port_oe == 8'hFF)
    else $error("port not showing latch");
  latch_load_a: assert property (
    i_ops.latch_load_op
    |=> out_latch == $past({i_data.acc, i_data.mem}))
    else $error("latch load wrong");
  enable_take_a: assert property (
    i_ops.enable_write_op |=> o_enable == $past(i_data.acc))
    else $error("enable write lost");
  count_out_a: assert property (
    serial_counter_select_bit |-> o_serial_out == serial_out_control_bit)
    else $error("serial out not bit 3");
  swap_both_a: assert property (
    (i_ops.acc_serial_swap_op && !i_ops.port_pins_read_op
     && !i_ops.latch_readback_op)
    |=> serial_shift_count_reg == $past(i_data.acc)
        && o_acc == $past(serial_shift_count_reg))
    else $error("swap not both ways");
  host_float_a: assert property (
    (i_host_mode && (gen_s[2] || gen_s[3])) |-> o_port_oe == 8'h00)
    else $error("host bus driven without strobes");
  ready_drive_a: assert property (
    i_host_mode |-> o_ready_oe && o_ready_request_line == i_ready_level)
    else $error("ready line floated");
  carry_clk_a: assert property (
    (serial_counter_select_bit && i_ops.acc_serial_swap_op
     && !i_ops.enable_write_op)
    |=> o_serial_clock_pin == $past(i_data.carry))
    else $error("clock pin not carry");
  catch_keep_a: assert property (
    (fall03[0] || (pulse_catch[0] && !take_latched)) |=> pulse_catch[0])
    else $error("pulse not caught");
  irq_gate_a: assert property (
    !input_interrupt_enable_bit |-> !o_irq_req)
    else $error("interrupt while disabled");
  latched_read_a: assert property (
    (take_latched && !i_ops.port_pins_read_op && !i_ops.latch_readback_op
     && !i_ops.acc_serial_swap_op && !i_ops.general_inputs_read_op)
    |=> o_acc_valid && o_acc[2] == $past(osc_s) && !o_acc[1])
    else $error("latched read wrong");
  shift_gate_a: assert property (
    (!serial_counter_select_bit && !serial_out_control_bit)
    |-> !o_serial_clock_pin)
    else $error("shift clock not gated");
  cover_swap_c: cover property (@(posedge i_clk) i_ops.acc_serial_swap_op);
  cover_host_c: cover property (@(posedge i_clk) i_host_mode && host_drive);
  cover_shift_c: cover property (@(posedge i_clk) do_shift);
  cover_irq_c: cover property (@(posedge i_clk) o_irq_req);
  cover_count_c: cover property (@(posedge i_clk) do_count);
endmodule

// *** rtl/sync2.sv ***
`timescale 1ns/10ps
module sync2 #(
  parameter int W = 1
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);
  logic [W-1:0] meta;
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      meta <= '1;
      o_q  <= '1;
    end
    else
    begin
      meta <= i_d;
      o_q  <= meta;
    end
  end
endmodule

// *** tb/shift_ext_model.sv ***
`timescale 1ns/10ps
module shift_ext_model (
  // pins from the block
  input  wire logic       i_clk,
  input  wire logic       i_sclk,
  input  wire logic       i_so,
  input  wire logic [7:0] i_port,
  input  wire logic [7:0] i_port_oe,
  // far side drive and capture
  input  wire logic [7:0] i_drive,
  output logic      [7:0] o_pins,
  output logic      [3:0] o_bits,
  output int              o_edges
);
  logic prev_sclk = 1'b0;
  logic prev_so = 1'b0;
  initial o_bits = 4'h0;
  initial o_edges = 0;
  // far side owns the lines whenever the block lets go
  assign o_pins = (i_port & i_port_oe) | (i_drive & ~i_port_oe);
  // takes the bit that stood before the shift edge; first four only
  always @(posedge i_clk)
  begin
    prev_sclk <= i_sclk;
    prev_so <= i_so;
    if (i_sclk === 1'b1 && prev_sclk === 1'b0)
    begin
      o_edges <= o_edges + 1;
      if (o_edges < 4)
        o_bits <= {o_bits[2:0], prev_so};
    end
  end
endmodule

// *** tb/tb.sv ***
`timescale 1ns/10ps
module tb;
  import io_port_pkg::*;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  cpu_ops_t   ops = '0;
  cpu_data_t  data = '0;
  logic       host = 1'b0;
  logic       rdy_lvl = 1'b0;
  logic       si = 1'b1;
  logic       osc = 1'b0;
  logic [3:0] gen = 4'hF;
  logic [7:0] drive = 8'h00;
  logic [7:0] r = 8'h1E;
  logic [3:0] acc, mem, en, bits;
  logic       vld, irq, so, sclk, rdy, rdy_oe;
  logic [7:0] pins, port, port_oe;
  logic [8:0] q[$];
  logic [8:0] e;
  int         edges, e0, i;
  int         irqs = 0;
  int         n_mismatch = 0;
  int         total_checks = 0;

  mcu_io_ports #(.SHIFT_DIV(2)) i_mcu_io_ports (
    .i_clk(clk), .i_rst(rst), .i_ops(ops), .i_data(data),
    .i_host_mode(host), .i_ready_level(rdy_lvl), .o_acc(acc),
    .o_mem(mem), .o_acc_valid(vld), .o_enable(en), .o_irq_req(irq),
    .i_port(pins), .o_port(port), .o_port_oe(port_oe),
    .i_serial_in(si), .o_serial_out(so), .o_serial_clock_pin(sclk),
    .i_gen_in(gen), .i_oscillator_out_pin(osc),
    .o_ready_request_line(rdy), .o_ready_oe(rdy_oe));

  shift_ext_model i_shift_ext_model (
    .i_clk(clk), .i_sclk(sclk), .i_so(so), .i_port(port),
    .i_port_oe(port_oe), .i_drive(drive), .o_pins(pins),
    .o_bits(bits), .o_edges(edges));

  initial forever #10 clk = ~clk;

  function automatic logic [7:0] nxt(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic cmp_pin(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %0t pin got %h exp %h", $time, got, exp);
    end
  endtask

  // k: 0 load 1 readback 2 pins 3 swap 4 gen 5 latched 6 enable
  task automatic op(input int k, input logic [3:0] a, input logic [3:0] m,
                    input logic c, input logic [8:0] x, input bit rd);
    @(negedge clk);
    ops = cpu_ops_t'(7'h40 >> k);
    data = '{a, m, c};
    if (rd)
      q.push_back(x);
    @(negedge clk);
    ops = '0;
  endtask

  task automatic conclude;
    // a read that never answered leaves its note behind
    if (q.size() != 0)
      n_mismatch++;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // bit 8 of a note asks for the memory nibble too
  always @(posedge clk)
  begin
    if (vld === 1'b1)
    begin
      if (q.size() == 0)
      begin
        n_mismatch++;
        $display("[ERR] %0t unexpected read %h exp %h", $time, {acc, mem},
                 8'h00);
      end
      else
      begin
        e = q.pop_front();
        cmp({acc, e[8] ? mem : 4'h0}, e[7:0]);
      end
    end
    if (irq === 1'b1)
      irqs++;
  end

  initial
  begin
    repeat (10) @(negedge clk);
    rst = 1'b0;
    // ----------------------------------------
    // parallel port
    // ----------------------------------------
    r = nxt(r);
    op(6, 4'h4, 4'h0, 1'b0, 9'h000, 0);
    op(0, r[7:4], r[3:0], 1'b0, 9'h000, 0);
    cmp_pin(port_oe, 8'hFF);
    cmp_pin(port, r);
    op(1, 4'h0, 4'h0, 1'b0, {1'b1, r}, 1);
    op(6, 4'h0, 4'h0, 1'b0, 9'h000, 0);
    cmp_pin(port_oe, 8'h00);
    cmp_pin(port, 8'h00);
    drive = nxt(r);
    repeat (3) @(negedge clk);
    op(2, 4'h0, 4'h0, 1'b0, {1'b1, drive}, 1);
    // host bus: strobes stand in for the host, input 1 held high
    op(6, 4'h4, 4'h0, 1'b0, 9'h000, 0);
    host = 1'b1;
    rdy_lvl = r[0];
    gen = 4'b0111;
    repeat (3) @(negedge clk);
    cmp_pin(port_oe, 8'h00);
    gen = 4'b0011;
    repeat (3) @(negedge clk);
    cmp_pin(port_oe, 8'hFF);
    cmp_pin(port, r);
    cmp_pin({6'h00, rdy_oe, rdy}, {6'h00, 1'b1, r[0]});
    gen = 4'hF;
    host = 1'b0;
    // ----------------------------------------
    // general inputs
    // ----------------------------------------
    for (i = 0; i < 2; i++)
    begin
      op(6, i == 0 ? 4'h2 : 4'h0, 4'h0, 1'b0, 9'h000, 0);
      gen[1] = 1'b0;
      repeat (3) @(negedge clk);
      gen[1] = 1'b1;
      repeat (4) @(negedge clk);
      cmp_pin(irqs[7:0], 8'h01);
    end
    op(5, 4'h0, 4'h0, 1'b0, 9'h080, 1);
    gen[0] = 1'b0;
    osc = 1'b1;
    repeat (3) @(negedge clk);
    gen[0] = 1'b1;
    repeat (3) @(negedge clk);
    op(5, 4'h0, 4'h0, 1'b0, 9'h050, 1);
    op(5, 4'h0, 4'h0, 1'b0, 9'h040, 1);
    r = nxt(drive);
    gen = r[3:0];
    repeat (3) @(negedge clk);
    op(4, 4'h0, 4'h0, 1'b0, {1'b0, r[3:0], 4'h0}, 1);
    // ----------------------------------------
    // serial register
    // ----------------------------------------
    op(3, 4'hA, 4'h0, 1'b0, 9'h000, 1);
    op(6, 4'h8, 4'h0, 1'b0, 9'h000, 0);
    for (i = 0; i < 200 && edges < 4; i++)
      @(negedge clk);
    cmp_pin({4'h0, bits}, 8'h0A);
    repeat (20) @(negedge clk);
    op(6, 4'h0, 4'h0, 1'b0, 9'h000, 0);
    e0 = edges;
    repeat (20) @(negedge clk);
    cmp_pin(edges[7:0], e0[7:0]);
    op(3, 4'h0, 4'h0, 1'b0, 9'h0F0, 1);
    op(6, 4'h9, 4'h0, 1'b0, 9'h000, 0);
    cmp_pin({7'h00, so}, 8'h01);
    // serial input as count clock: 160 ns period, five falls
    for (i = 0; i < 10; i++)
    begin
      repeat (4) @(negedge clk);
      si = ~si;
    end
    repeat (4) @(negedge clk);
    op(3, 4'h3, 4'h0, 1'b1, 9'h050, 1);
    cmp_pin({7'h00, sclk}, 8'h01);
    op(3, 4'h0, 4'h0, 1'b0, 9'h030, 1);
    cmp_pin({7'h00, sclk}, 8'h00);
    repeat (4) @(negedge clk);
    if (edges < 4)
      n_mismatch++;
    conclude();
  end
endmodule
